// >>> design/twi_pkg.sv
// Purpose: shared constants and types for the two-wire bus master block
// Assumes: 16-bit registers on a plain strobe port, printed offsets are byte addresses
// Notes: field positions follow the control and status register layouts
package twi_pkg;
	localparam logic [9:0] rx_buffer_addr = 10'h200;
	localparam logic [9:0] tx_buffer_addr = 10'h202;
	localparam logic [9:0] clock_divider_addr = 10'h204;
	localparam logic [9:0] control_addr = 10'h206;
	localparam logic [9:0] status_addr = 10'h208;
	localparam logic [9:0] own_address_addr = 10'h20a;
	localparam logic [15:0] rx_buffer_reset = 16'h0000;
	localparam logic [15:0] tx_buffer_reset = 16'h00ff;
	localparam logic [15:0] clock_divider_reset = 16'h0000;
	localparam logic [15:0] control_reset = 16'h1000;
	localparam logic [15:0] status_reset = 16'h0000;
	localparam logic [15:0] own_address_reset = 16'h0000;
	// control bit positions
	localparam int ctl_enable = 15;
	localparam int ctl_stop_in_idle = 13;
	localparam int ctl_clock_release = 12;
	localparam int ctl_accept_all = 11;
	localparam int ctl_broadcast = 7;
	localparam int ctl_stretch = 6;
	localparam int ctl_ack_value = 5;
	localparam int ctl_ack_req = 4;
	localparam int ctl_receive_req = 3;
	localparam int ctl_stop_req = 2;
	localparam int ctl_restart_req = 1;
	localparam int ctl_start_req = 0;
	// status bit positions
	localparam int st_ack_status = 15;
	localparam int st_tx_progress = 14;
	localparam int st_collision = 10;
	localparam int st_broadcast_hit = 9;
	localparam int st_stop_seen = 4;
	localparam int st_start_seen = 3;
	localparam int st_rx_full = 1;
	localparam int st_tx_full = 0;
	localparam logic [7:0] broadcast_address = 8'h00;
	localparam logic [3:0] bits_per_byte = 4'h8;
	localparam int bus_width = 16;
	typedef enum {idle, start_a, start_b, restart_a, restart_b, restart_c, stop_a, stop_b, stop_c,
		bit_low, bit_high, ack_low, ack_high, wait_sw} master_state_t;
	typedef struct packed {
		logic scl;
		logic sda;
	} bus_lines_t;
	typedef struct packed {
		logic master_event;
		logic slave_event;
	} events_t;
endpackage

// >>> design/twi_master.sv
// Purpose: two-wire bus master with broadcast and accept-all address recognition
// Assumes: open-drain pins split into level in and pull-low enable; pins pass two flops first
// Notes: one shared reload-and-count-down generator paces every bus phase
//
// Function
// - accept-all bit makes every address match
// - broadcast recognised only with enable bit 7
// - after start shift eight bits, compare addresses
// - broadcast hit fills buffer, flags, ninth-fall event
// - restart begins next transfer holding bus
// - transmitter sends address, bytes, samples acknowledge
// - receiver gets bytes, drives acknowledge on ack request
// - transmit write sets full flag, starts generator
// - data bit placed after driven clock fall
// - status bit 14 high during transmit
// - receive request bit 3 ignored unless in wait_sw
// - rollover toggles clock, sample on rise
// - generator loads, counts to zero, reloads
// - released clock pauses generator until sampled high
// - released one read zero flags collision
// - collision in byte clears full flag, releases
// - collision in sequence clears request bits
// - after collision stop detection raises event
// - sleep stops clocks, aborts transfer
// - idle mode halts when stop-in-idle set
// - master and slave event flags raised
// - clock-release clear holds clock after fall
//
// Local design decision: strobed register access.
`timescale 1ns/10ps
module twi_master (
	input wire logic clk, // 20 MHz system clock
	input wire logic reset, // synchronous, active high
	input wire logic [9:0] addr, // register byte address
	input wire logic [15:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	output logic [15:0] rdata, // read data, cycle after rd
	input wire logic sleep, // processor sleep
	input wire logic cpu_idle, // processor idle
	input wire twi_pkg::bus_lines_t pins_in, // pin levels
	output twi_pkg::bus_lines_t pins_oe, // high pulls the line low
	output twi_pkg::events_t events // one-cycle event pulses
);
	logic [15:0] rx_buffer_reg, tx_buffer_reg, clock_divider_reg, control_reg, status_reg, own_address_reg;
	logic [7:0] rx_shift_reg, tx_shift;
	logic [15:0] clock_generator;
	logic [3:0] bit_count;
	logic scl_s1, scl_s, sda_s1, sda_s, scl_d, sda_d;
	logic scl_oe, sda_oe, receiving, addr_phase, collided, slave_watch, slave_bits_active;
	logic [3:0] slave_count;
	logic [7:0] slave_shift;
	logic slave_hit_pending, slave_broadcast_pending, stretch_hold;
	twi_pkg::master_state_t state;
	logic master_event, slave_event;

	function automatic logic rolled(input logic [15:0] count);
		rolled = (count == 16'h0000);
	endfunction

	// two-flop synchronisers on the pins, then edge history from the second stage
	always_ff @(posedge clk) begin
		scl_s1 <= pins_in.scl;
		scl_s <= scl_s1;
		sda_s1 <= pins_in.sda;
		sda_s <= sda_s1;
		scl_d <= scl_s;
		sda_d <= sda_s;
	end

	// run gating: sleep aborts, idle halts when requested
	wire run = control_reg[twi_pkg::ctl_enable] && !sleep
		&& !(cpu_idle && control_reg[twi_pkg::ctl_stop_in_idle]);
	wire start_cond = scl_s && scl_d && sda_d && !sda_s;
	wire stop_cond = scl_s && scl_d && !sda_d && sda_s;
	wire scl_rise = scl_s && !scl_d;
	wire scl_fall = !scl_s && scl_d;
	// register decode
	wire hit_tx = wr && (addr == twi_pkg::tx_buffer_addr);
	wire hit_div = wr && (addr == twi_pkg::clock_divider_addr);
	wire hit_ctl = wr && (addr == twi_pkg::control_addr);
	wire hit_stat = wr && (addr == twi_pkg::status_addr);
	wire hit_own = wr && (addr == twi_pkg::own_address_addr);
	wire read_rx = rd && (addr == twi_pkg::rx_buffer_addr);
	wire master_idle = (state == twi_pkg::idle);
	// generator paused while our released clock is still held low by another party
	wire scl_stalled = !scl_oe && !scl_s;
	wire tick = rolled(clock_generator) && !scl_stalled;
	// collision: we release data to send a one but the line reads zero with clock high
	wire bus_collision = run && !master_idle && !sda_oe && !sda_s && scl_s && !scl_oe
		&& (state == twi_pkg::bit_high || state == twi_pkg::start_a || state == twi_pkg::restart_b
		|| state == twi_pkg::stop_c || (state == twi_pkg::ack_high && bit_count != 4'h0)) && !receiving;
	wire tx_accept = hit_tx && run && (master_idle || state == twi_pkg::wait_sw);
	wire [15:0] ctl_wmask = 16'hfff0 & ~(16'h1 << twi_pkg::ctl_clock_release);
	wire byte_broadcast = control_reg[twi_pkg::ctl_broadcast] && (slave_shift == twi_pkg::broadcast_address);
	wire byte_own = (slave_shift[7:1] == own_address_reg[6:0]) || control_reg[twi_pkg::ctl_accept_all];

	// reload-and-count-down generator; reloads on every phase step and when a stretched clock returns
	always_ff @(posedge clk) begin
		if (reset || !run) begin
			clock_generator <= twi_pkg::clock_divider_reset;
		end else if (tick || (scl_rise && !scl_oe) || tx_accept || hit_ctl) begin
			clock_generator <= clock_divider_reg;
		end else if (!rolled(clock_generator) && !scl_stalled) begin
			clock_generator <= clock_generator - 16'h0001;
		end
	end

	// master sequencer: every phase except idle and wait_sw advances on a generator rollover
	always_ff @(posedge clk) begin
		master_event <= 1'b0;
		if (reset || !run) begin
			state <= twi_pkg::idle;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			bit_count <= 4'h0;
			receiving <= 1'b0;
			tx_shift <= 8'h00;
			addr_phase <= 1'b1;
			rx_shift_reg <= 8'h00;
		end else if (bus_collision) begin
			state <= twi_pkg::idle;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			master_event <= 1'b1;
			bit_count <= 4'h0;
		end else begin
			if (collided && stop_cond) begin
				master_event <= 1'b1;
			end
			case (state)
				twi_pkg::idle: begin
					if (tx_accept) begin
						tx_shift <= wdata[7:0];
						bit_count <= twi_pkg::bits_per_byte;
						receiving <= 1'b0;
						state <= twi_pkg::bit_low;
					end else if (control_reg[twi_pkg::ctl_start_req]) begin
						sda_oe <= 1'b1;
						state <= twi_pkg::start_a;
						addr_phase <= 1'b1;
					end
				end
				twi_pkg::start_a: if (tick) begin
					scl_oe <= 1'b1;
					state <= twi_pkg::start_b;
				end
				twi_pkg::start_b: if (tick) begin
					master_event <= 1'b1;
					state <= twi_pkg::wait_sw;
				end
				twi_pkg::wait_sw: begin
					if (tx_accept) begin
						tx_shift <= wdata[7:0];
						bit_count <= twi_pkg::bits_per_byte;
						receiving <= 1'b0;
						state <= twi_pkg::bit_low;
					end else if (control_reg[twi_pkg::ctl_receive_req]) begin
						bit_count <= twi_pkg::bits_per_byte;
						receiving <= 1'b1;
						sda_oe <= 1'b0;
						state <= twi_pkg::bit_low;
					end else if (control_reg[twi_pkg::ctl_ack_req]) begin
						sda_oe <= !control_reg[twi_pkg::ctl_ack_value];
						bit_count <= 4'h1; // marks our own ack slot
						state <= twi_pkg::ack_low;
					end else if (control_reg[twi_pkg::ctl_restart_req]) begin
						sda_oe <= 1'b0;
						state <= twi_pkg::restart_a;
					end else if (control_reg[twi_pkg::ctl_stop_req]) begin
						sda_oe <= 1'b1;
						state <= twi_pkg::stop_a;
					end
				end
				// clock is low: put the next bit on data after the driven fall
				twi_pkg::bit_low: if (tick) begin
					if (bit_count == 4'h0 && receiving) begin
						receiving <= 1'b0; // byte in, clock held low
						master_event <= 1'b1;
						state <= twi_pkg::wait_sw;
					end else if (bit_count == 4'h0) begin
						sda_oe <= 1'b0; // free data before the ack clock rises
						state <= twi_pkg::ack_low;
					end else if (receiving) begin
						scl_oe <= 1'b0;
						state <= twi_pkg::bit_high;
					end else begin
						sda_oe <= !tx_shift[7];
						tx_shift <= {tx_shift[6:0], 1'b0};
						state <= twi_pkg::bit_high;
					end
				end
				twi_pkg::bit_high: begin
					if (receiving && scl_rise) begin
						rx_shift_reg <= {rx_shift_reg[6:0], sda_s};
					end
					if (tick) begin
						if (!receiving && scl_oe) begin
							scl_oe <= 1'b0;
						end else begin
							scl_oe <= 1'b1;
							bit_count <= bit_count - 4'h1;
							state <= twi_pkg::bit_low;
						end
					end
				end
				twi_pkg::ack_low: if (tick) begin
					scl_oe <= 1'b0;
					state <= twi_pkg::ack_high;
				end
				twi_pkg::ack_high: if (tick) begin
					scl_oe <= 1'b1; // data stays put while the clock falls
					addr_phase <= 1'b0;
					receiving <= 1'b0;
					bit_count <= 4'h0;
					master_event <= 1'b1;
					state <= twi_pkg::wait_sw;
				end
				twi_pkg::restart_a: if (tick) begin
					scl_oe <= 1'b0;
					state <= twi_pkg::restart_b;
				end
				twi_pkg::restart_b: if (tick) begin
					sda_oe <= 1'b1;
					state <= twi_pkg::restart_c;
				end
				twi_pkg::restart_c: if (tick) begin
					scl_oe <= 1'b1;
					addr_phase <= 1'b1;
					master_event <= 1'b1;
					state <= twi_pkg::wait_sw;
				end
				twi_pkg::stop_a: if (tick) begin
					scl_oe <= 1'b0;
					state <= twi_pkg::stop_b;
				end
				twi_pkg::stop_b: if (tick) begin
					sda_oe <= 1'b0;
					state <= twi_pkg::stop_c;
				end
				default: if (tick) begin
					master_event <= 1'b1;
					state <= twi_pkg::idle;
				end
			endcase
		end
	end

	// address watcher: after any start, shift eight bits and compare
	always_ff @(posedge clk) begin
		slave_event <= 1'b0;
		if (reset || !run) begin
			slave_bits_active <= 1'b0;
			slave_count <= 4'h0;
			slave_shift <= 8'h00;
			slave_hit_pending <= 1'b0;
			slave_broadcast_pending <= 1'b0;
		end else if (start_cond) begin
			slave_bits_active <= 1'b1;
			slave_count <= 4'h0;
			slave_hit_pending <= 1'b0;
			slave_broadcast_pending <= 1'b0;
		end else if (slave_bits_active && scl_rise) begin
			if (slave_count == twi_pkg::bits_per_byte) begin
				slave_bits_active <= 1'b0;
			end else begin
				slave_shift <= {slave_shift[6:0], sda_s};
				slave_count <= slave_count + 4'h1;
			end
		end else if (slave_bits_active && scl_fall && slave_count == twi_pkg::bits_per_byte) begin
			slave_broadcast_pending <= byte_broadcast;
			slave_hit_pending <= byte_own && !byte_broadcast;
		end else if (!slave_bits_active && scl_fall && (slave_hit_pending || slave_broadcast_pending)) begin
			slave_event <= slave_hit_pending;
			slave_hit_pending <= 1'b0;
			slave_broadcast_pending <= 1'b0;
		end
	end
	wire broadcast_load = slave_bits_active && scl_fall && slave_count == twi_pkg::bits_per_byte && byte_broadcast;
	wire broadcast_event = !slave_bits_active && scl_fall && slave_broadcast_pending;
	wire rx_done = state == twi_pkg::bit_low && receiving && tick && bit_count == 4'h0;

	// software clock hold: only takes hold after a falling edge with the line low
	always_ff @(posedge clk) begin
		if (reset) begin
			stretch_hold <= 1'b0;
		end else if (control_reg[twi_pkg::ctl_clock_release]) begin
			stretch_hold <= 1'b0;
		end else if (scl_fall || (stretch_hold && !scl_s)) begin
			stretch_hold <= 1'b1;
		end
	end

	// control register: hardware clears request bits on completion or collision
	wire seq_done = tick && (state == twi_pkg::start_b || state == twi_pkg::restart_c
		|| state == twi_pkg::stop_c || (state == twi_pkg::ack_high && !receiving && bit_count != 4'h0));
	wire rx_start = state == twi_pkg::wait_sw && control_reg[twi_pkg::ctl_receive_req] && !tx_accept;
	always_ff @(posedge clk) begin
		if (reset) begin
			control_reg <= twi_pkg::control_reset;
		end else if (hit_ctl) begin
			control_reg <= (wdata & ctl_wmask) | (control_reg & ~ctl_wmask)
				| ({15'h0000, master_idle && wdata[twi_pkg::ctl_start_req]})
				| {12'h000, wdata[twi_pkg::ctl_receive_req] && state == twi_pkg::wait_sw,
					wdata[twi_pkg::ctl_stop_req], wdata[twi_pkg::ctl_restart_req], 1'b0};
			if (control_reg[twi_pkg::ctl_stretch]) begin
				control_reg[twi_pkg::ctl_clock_release] <= wdata[twi_pkg::ctl_clock_release];
			end
		end else if (bus_collision || !run) begin
			control_reg[4:0] <= 5'b00000;
		end else if (seq_done || rx_start) begin
			control_reg[4:0] <= 5'b00000;
		end
	end

	// status and buffers; hardware set wins over software clear
	always_ff @(posedge clk) begin
		if (reset) begin
			status_reg <= twi_pkg::status_reset;
			rx_buffer_reg <= twi_pkg::rx_buffer_reset;
			tx_buffer_reg <= twi_pkg::tx_buffer_reset;
			clock_divider_reg <= twi_pkg::clock_divider_reset;
			own_address_reg <= twi_pkg::own_address_reset;
			collided <= 1'b0;
		end else begin
			if (hit_div) clock_divider_reg <= wdata;
			if (hit_own) own_address_reg <= wdata;
			if (hit_stat && !wdata[twi_pkg::st_collision]) begin
				status_reg[twi_pkg::st_collision] <= 1'b0;
				collided <= 1'b0;
			end
			if (tx_accept) begin
				tx_buffer_reg <= {8'h00, wdata[7:0]};
				status_reg[twi_pkg::st_tx_full] <= 1'b1;
			end else if (!run || (state == twi_pkg::bit_low && bit_count == 4'h1 && tick)) begin
				status_reg[twi_pkg::st_tx_full] <= 1'b0;
			end
			status_reg[twi_pkg::st_tx_progress] <= !master_idle && !receiving
				&& (state == twi_pkg::bit_low || state == twi_pkg::bit_high || state == twi_pkg::ack_high);
			if (state == twi_pkg::ack_high && !receiving && tick) status_reg[twi_pkg::st_ack_status] <= sda_s;
			if (read_rx) status_reg[twi_pkg::st_rx_full] <= 1'b0;
			if (broadcast_load) begin
				rx_buffer_reg <= {8'h00, slave_shift};
				status_reg[twi_pkg::st_rx_full] <= 1'b1;
				status_reg[twi_pkg::st_broadcast_hit] <= 1'b1;
			end else if (rx_done) begin
				rx_buffer_reg <= {8'h00, rx_shift_reg};
				status_reg[twi_pkg::st_rx_full] <= 1'b1;
			end
			if (start_cond) begin
				status_reg[twi_pkg::st_start_seen] <= 1'b1;
				status_reg[twi_pkg::st_stop_seen] <= 1'b0;
			end else if (stop_cond) begin
				status_reg[twi_pkg::st_stop_seen] <= 1'b1;
				status_reg[twi_pkg::st_start_seen] <= 1'b0;
				status_reg[twi_pkg::st_broadcast_hit] <= 1'b0;
			end
			if (bus_collision) begin
				status_reg[twi_pkg::st_collision] <= 1'b1;
				status_reg[twi_pkg::st_tx_full] <= 1'b0;
				collided <= 1'b1;
			end
		end
	end

	// read mux and registered outputs
	wire [15:0] read_mux = (addr == twi_pkg::rx_buffer_addr) ? rx_buffer_reg
		: (addr == twi_pkg::tx_buffer_addr) ? tx_buffer_reg
		: (addr == twi_pkg::clock_divider_addr) ? clock_divider_reg
		: (addr == twi_pkg::control_addr) ? control_reg
		: (addr == twi_pkg::status_addr) ? status_reg
		: (addr == twi_pkg::own_address_addr) ? own_address_reg : 16'h0000;
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata <= 16'h0000;
			pins_oe <= '0;
			events <= '0;
		end else begin
			rdata <= rd ? read_mux : 16'h0000;
			pins_oe.scl <= run && (scl_oe || (stretch_hold && control_reg[twi_pkg::ctl_stretch]));
			pins_oe.sda <= run && sda_oe;
			events.master_event <= master_event || broadcast_event;
			events.slave_event <= slave_event;
		end
	end
endmodule

// >>> testbench/twi_master_props.sv
// Purpose: port-level assertions for the two-wire master
// Assumes: divider of 2 or more, so every clock phase lasts at least 3 cycles
// Notes: bound to every twi_master instance
`timescale 1ns/10ps
module twi_master_checker (
	input wire logic clk, // system clock
	input wire logic reset, // synchronous reset
	input wire logic [9:0] addr, // register address
	input wire logic [15:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	input wire logic [15:0] rdata, // read data
	input wire logic sleep, // sleep level
	input wire logic cpu_idle, // idle level
	input wire twi_pkg::bus_lines_t pins_in, // line levels
	input wire twi_pkg::bus_lines_t pins_oe, // pull-low enables
	input wire twi_pkg::events_t events // event pulses
);
	// one clock domain, quiet during reset
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	// clock line edges made by the master
	sequence s_scl_pulled;
		$rose(pins_oe.scl);
	endsequence
	sequence s_scl_freed;
		$fell(pins_oe.scl);
	endsequence
	// data pulled low while the clock is free: start or restart
	sequence s_start_edge;
		$rose(pins_oe.sda) && !pins_oe.scl;
	endsequence
	property p_rdata_idle;
		!rd |=> rdata == 16'h0000;
	endproperty
	property p_reset_quiet;
		disable iff (1'b0) reset |=> pins_oe == 2'h0 && events == 2'h0 && rdata == 16'h0000;
	endproperty
	property p_event_pulse;
		events.master_event |=> !events.master_event;
	endproperty
	property p_start_hold;
		disable iff (reset || sleep) s_start_edge |=> pins_oe.sda [*2];
	endproperty
	property p_scl_low_min;
		disable iff (reset || sleep) s_scl_pulled |-> pins_oe.scl [*3];
	endproperty
	property p_scl_high_min;
		disable iff (reset || sleep) s_scl_freed |-> !pins_oe.scl [*3];
	endproperty
	property p_sda_steady_pull;
		disable iff (reset || sleep) s_scl_pulled |-> $stable(pins_oe.sda);
	endproperty
	property p_sda_steady_free;
		disable iff (reset || sleep) s_scl_freed |-> $stable(pins_oe.sda);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside a read");
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
	a_event_pulse: assert property (p_event_pulse) else $error("master event longer than one cycle");
	a_start_hold: assert property (p_start_hold) else $error("start condition too short");
	a_scl_low_min: assert property (p_scl_low_min) else $error("clock low shorter than a rollover");
	a_scl_high_min: assert property (p_scl_high_min) else $error("clock high shorter than a rollover");
	a_sda_steady_pull: assert property (p_sda_steady_pull) else $error("data moved with clock fall");
	a_sda_steady_free: assert property (p_sda_steady_free) else $error("data moved with clock rise");
endmodule
bind twi_master twi_master_checker props_i (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
	.rd(rd), .rdata(rdata), .sleep(sleep), .cpu_idle(cpu_idle), .pins_in(pins_in), .pins_oe(pins_oe),
	.events(events));

// >>> testbench/twi_slave_model.sv
// Purpose: behavioural bus slave that acknowledges and answers reads
// Assumes: both lines pulled up; an enable drags its line low
// Notes: optional clock stretching after every clock fall
`timescale 1ns/10ps
module twi_slave_model #(
	parameter logic [7:0] reply = 8'h5c // byte returned on reads
) (
	input wire logic clk, // times the stretch
	input wire logic scl, // clock line
	input wire logic sda, // data line
	input wire logic [3:0] stretch, // extra low cycles, 0 none
	output logic scl_oe, // pulls clock low
	output logic sda_oe, // pulls data low
	output logic [7:0] got_byte, // last byte on the bus
	output logic got_ack, // last ack slot level
	output logic stop_seen // stop since last start
);
	logic [7:0] shift = 8'h00;
	int cnt = 0;
	logic first = 1'b0;
	logic reading = 1'b0;
	// outputs start released
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
		got_byte = 8'h00;
		got_ack = 1'b0;
		stop_seen = 1'b0;
	end
	// start and stop: data edges while the clock is high
	always @(negedge sda) if (scl) begin
		cnt = 0;
		first = 1'b1;
		reading = 1'b0;
		stop_seen = 1'b0;
	end
	always @(posedge sda) if (scl) stop_seen = 1'b1;
	// sample on the rising clock, ninth bit is the ack slot
	always @(posedge scl) begin
		if (cnt < 8) shift = {shift[6:0], sda};
		else begin
			got_ack = sda;
			first = 1'b0;
			if (sda) reading = 1'b0; // not-acknowledge ends a read
		end
		if (cnt == 7) begin
			got_byte = shift;
			if (first) reading = shift[0];
		end
		cnt = (cnt == 8) ? 0 : cnt + 1;
	end
	// drive after the falling clock: ack, or the reply bits
	always @(negedge scl) begin
		if (cnt == 8 && (first || !reading)) sda_oe = 1'b1;
		else sda_oe = reading && !first && cnt < 8 && !reply[7 - cnt];
	end
	// slow mode holds the clock low a while
	always @(negedge scl) if (stretch != 4'h0) begin
		scl_oe = 1'b1;
		repeat (stretch) @(posedge clk);
		scl_oe = 1'b0;
	end
endmodule

// >>> testbench/tb_i2c_master_general_call.sv
// Purpose: self-checking bench for the two-wire master
// Assumes: divider 4, slave model on the bus, rival master as a data pull
// Notes: each scenario is one task
`timescale 1ns/10ps
module tb_i2c_master_general_call;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [9:0] addr = 10'h000;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic sleep = 1'b0;
	logic cpu_idle = 1'b0;
	logic rival_sda = 1'b0;
	logic [3:0] stretch = 4'h0;
	logic [15:0] rdata;
	logic [15:0] val;
	logic [7:0] got_byte;
	logic slave_scl_oe, slave_sda_oe, got_ack, stop_seen;
	twi_pkg::bus_lines_t pins_in;
	twi_pkg::bus_lines_t pins_oe;
	twi_pkg::events_t events;
	int error_cnt = 0;
	int samples_checked = 0;
	int cyc = 0;
	always #25 clk = ~clk;
	// open-drain lines: any enabled party pulls low
	assign pins_in.scl = !(pins_oe.scl || slave_scl_oe);
	assign pins_in.sda = !(pins_oe.sda || slave_sda_oe || rival_sda);
	twi_master dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.sleep(sleep), .cpu_idle(cpu_idle), .pins_in(pins_in), .pins_oe(pins_oe), .events(events));
	twi_slave_model peer (.clk(clk), .scl(pins_in.scl), .sda(pins_in.sda), .stretch(stretch),
		.scl_oe(slave_scl_oe), .sda_oe(slave_sda_oe), .got_byte(got_byte), .got_ack(got_ack),
		.stop_seen(stop_seen));
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			error_cnt++;
			$display("mismatch run length expected finished seen running");
			tally_and_finish();
		end
	end
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr_reg(input logic [9:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_reg(input logic [9:0] a, output logic [15:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
		@(posedge clk);
	endtask
	// bounded wait for the next master event pulse
	task automatic wait_master();
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (events.master_event !== 1'b1 && n < 3000);
		chk("master event", 16'h0001, {15'h0000, events.master_event});
		@(posedge clk);
	endtask
	task automatic begin_transfer();
		wr_reg(twi_pkg::control_addr, 16'h9001);
		wait_master();
		rd_reg(twi_pkg::control_addr, val);
		chk("start request", 16'h9000, val);
	endtask
	task automatic send_byte(input logic [7:0] b);
		wr_reg(twi_pkg::tx_buffer_addr, {8'h00, b});
		wait_master();
	endtask
	task automatic finish_transfer();
		wr_reg(twi_pkg::control_addr, 16'h9004);
		wait_master();
		chk("stop on bus", 16'h0001, {15'h0000, stop_seen});
		rd_reg(twi_pkg::control_addr, val);
		chk("stop request", 16'h9000, val);
	endtask
	task automatic check_reset_values();
		logic [9:0] ra [6];
		logic [15:0] re [6];
		ra = '{twi_pkg::rx_buffer_addr, twi_pkg::tx_buffer_addr, twi_pkg::clock_divider_addr,
			twi_pkg::control_addr, twi_pkg::status_addr, twi_pkg::own_address_addr};
		re = '{16'h0000, 16'h00ff, 16'h0000, 16'h1000, 16'h0000, 16'h0000};
		for (int i = 0; i < 6; i++) begin
			rd_reg(ra[i], val);
			chk("reset value", re[i], val);
		end
		rd_reg(10'h20c, val);
		chk("unmapped read", 16'h0000, val);
		wr_reg(twi_pkg::rx_buffer_addr, 16'h1234);
		rd_reg(twi_pkg::rx_buffer_addr, val);
		chk("receive buffer write", 16'h0000, val);
	endtask
	task automatic master_write();
		cpu_idle <= 1'b1; // stop-in-idle clear keeps it running
		wr_reg(twi_pkg::clock_divider_addr, 16'h0004); // legal divider
		begin_transfer();
		wr_reg(twi_pkg::tx_buffer_addr, 16'h00a6);
		rd_reg(twi_pkg::status_addr, val);
		chk("full and busy", 16'h4001, val & 16'h4001);
		wr_reg(twi_pkg::control_addr, 16'h9008);
		rd_reg(twi_pkg::control_addr, val);
		chk("receive while busy", 16'h0000, val & 16'h0008);
		wait_master();
		chk("address byte", 16'h00a6, {8'h00, got_byte});
		rd_reg(twi_pkg::status_addr, val);
		chk("acked and done", 16'h0000, val & 16'hc001);
		send_byte(8'h3c);
		chk("data byte", 16'h003c, {8'h00, got_byte});
		finish_transfer();
		cpu_idle <= 1'b0;
	endtask
	task automatic master_read();
		int n;
		stretch <= 4'h6; // slow slave holds the clock low
		begin_transfer();
		send_byte(8'ha6);
		wr_reg(twi_pkg::control_addr, 16'h9002);
		wait_master();
		chk("bus kept", 16'h0000, {15'h0000, stop_seen});
		send_byte(8'ha7);
		chk("read address", 16'h00a7, {8'h00, got_byte});
		wr_reg(twi_pkg::control_addr, 16'h9008);
		n = 0;
		do begin
			rd_reg(twi_pkg::status_addr, val);
			n++;
		end while (val[twi_pkg::st_rx_full] !== 1'b1 && n < 300);
		chk("receive full", 16'h0002, val & 16'h0002);
		rd_reg(twi_pkg::rx_buffer_addr, val);
		chk("received byte", 16'h005c, val);
		wr_reg(twi_pkg::control_addr, 16'h9030);
		wait_master();
		chk("ack level", 16'h0001, {15'h0000, got_ack});
		rd_reg(twi_pkg::control_addr, val);
		chk("ack request", 16'h9020, val);
		finish_transfer();
		stretch <= 4'h0;
	endtask
	task automatic broadcast();
		wr_reg(twi_pkg::control_addr, 16'h9081);
		wait_master();
		send_byte(8'h00); // all-zero write address
		wait_master(); // ninth fall
		rd_reg(twi_pkg::status_addr, val);
		chk("broadcast hit", 16'h0202, val & 16'h0202);
		rd_reg(twi_pkg::rx_buffer_addr, val);
		chk("broadcast byte", 16'h0000, val);
		finish_transfer();
	endtask
	task automatic collision();
		begin_transfer();
		rival_sda <= 1'b1; // rival pulls data low while the clock is low and holds it through the clock-high phase
		wr_reg(twi_pkg::tx_buffer_addr, 16'h00ff);
		wait_master();
		rd_reg(twi_pkg::status_addr, val);
		chk("collision status", 16'h0400, val & 16'h4401);
		chk("lines released", 16'h0000, {14'h0000, pins_oe});
		rd_reg(twi_pkg::control_addr, val);
		chk("requests cleared", 16'h9000, val);
		rival_sda <= 1'b0; // release with the clock high is a stop
		wait_master();
		rd_reg(twi_pkg::status_addr, val);
		chk("stop seen", 16'h0010, val & 16'h0010);
		wr_reg(twi_pkg::status_addr, 16'h0000);
	endtask
	task automatic sleep_abort();
		begin_transfer(); // bus free after the stop
		wr_reg(twi_pkg::tx_buffer_addr, 16'h0055);
		repeat (6) @(posedge clk);
		sleep <= 1'b1;
		repeat (10) @(posedge clk);
		sleep <= 1'b0;
		@(posedge clk);
		rd_reg(twi_pkg::status_addr, val);
		chk("transfer aborted", 16'h0000, val & 16'h4001);
		chk("lines after sleep", 16'h0000, {14'h0000, pins_oe});
	endtask
	// main sequence
	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		check_reset_values();
		master_write();
		master_read();
		broadcast();
		collision();
		sleep_abort();
		tally_and_finish();
	end
endmodule
